// file: src/rtsm_defs.vh
// Register offsets, field positions, reset values, mode and response codes for the touch matrix
`ifndef RTSM_DEFS_VH
`define RTSM_DEFS_VH

// ==========================================================================
// Register byte offsets (register index times four)
// ==========================================================================
`define RTSM_IDX_TOUCH_CTRL   4'h9
`define RTSM_OFF_TOUCH_CTRL   8'h24
`define RTSM_OFF_ADC_SEL      8'h28
`define RTSM_OFF_INT_STATUS   8'h2c
`define RTSM_OFF_INT_MASK     8'h30
`define RTSM_OFF_STATE        8'h34

// ==========================================================================
// Touch control register fields
// ==========================================================================
`define RTSM_TC_XP_PWR        0
`define RTSM_TC_XP_GND        1
`define RTSM_TC_XN_PWR        2
`define RTSM_TC_XN_GND        3
`define RTSM_TC_YP_PWR        4
`define RTSM_TC_YP_GND        5
`define RTSM_TC_YN_PWR        6
`define RTSM_TC_YN_GND        7
`define RTSM_TC_PRESS_EN      8
`define RTSM_TC_RELEASE_EN    9
`define RTSM_TC_MODE_LO       10
`define RTSM_TC_MODE_HI       11
`define RTSM_TC_BIAS_EN       12
`define RTSM_TC_STANDBY       13
`define RTSM_TC_WIDTH         14
`define RTSM_TC_RESET         14'h0000

// ==========================================================================
// Mode encodings and converter input codes
// ==========================================================================
`define RTSM_MODE_INTERRUPT   2'h0
`define RTSM_MODE_PRESSURE    2'h1
`define RTSM_ADC_SEL_RESET    3'h0
`define RTSM_ADC_SEL_CURMON   3'h4

// ==========================================================================
// Interrupt status bits
// ==========================================================================
`define RTSM_INT_PRESS        0
`define RTSM_INT_RELEASE      1
`define RTSM_INT_CONFLICT     2

// ==========================================================================
// AXI responses
// ==========================================================================
`define RTSM_RESP_OKAY        2'h0
`define RTSM_RESP_SLVERR      2'h2

`endif

// file: src/rtsm_touch_matrix.v
// Four-wire resistive touch panel switch matrix with AXI4-Lite registers and press interrupt
`timescale 1ns/1ns
`include "rtsm_defs.vh"

module rtsm_touch_matrix #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Filtered Schmitt detector outputs of the X plate terminals
  input  wire              x_pos_detect,
  input  wire              x_neg_detect,
  // Switch matrix controls, one power and one ground switch per terminal
  output reg               x_plate_pos_term_pwr,
  output reg               x_plate_pos_term_gnd,
  output reg               x_plate_neg_term_pwr,
  output reg               x_plate_neg_term_gnd,
  output reg               y_plate_pos_term_pwr,
  output reg               y_plate_pos_term_gnd,
  output reg               y_plate_neg_term_pwr,
  output reg               y_plate_neg_term_gnd,
  // Bias source selection
  output reg               bias_resistor_en,
  output reg               bias_circuit_en,
  // Converter input multiplexer code
  output reg  [2:0]        adc_input_route,
  // Interrupt
  output reg               irq
);

  // ========================================================================
  // Register state
  // ========================================================================
  reg [`RTSM_TC_WIDTH-1:0] touch_ctrl;
  reg [2:0]                adc_sel;
  reg [2:0]                int_status;
  reg [2:0]                int_mask;
  reg                      detect_prev;
  reg                      aw_held;
  reg                      w_held;
  reg [ADDR_W-1:0]         aw_addr;
  reg [31:0]               w_data;
  reg [3:0]                w_strb;

  // Resolve one terminal: grounding wins when both switches are requested
  function [1:0] resolve;
    input pwr;
    input gnd;
    begin
      resolve = {pwr & ~gnd, gnd};
    end
  endfunction

  // Byte-lane merge for a 32-bit register write
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Register select bits, one per mapped word
  localparam HIT_CTRL  = 0;
  localparam HIT_ADC   = 1;
  localparam HIT_STAT  = 2;
  localparam HIT_MASK  = 3;
  localparam HIT_STATE = 4;

  // Address decode shared by the write path, the status clear and the read path;
  // an all-zero result means the address is unmapped and earns SLVERR
  function [4:0] reg_hit;
    input [ADDR_W-1:0] addr;
    begin
      reg_hit = 5'h00;
      if (addr == `RTSM_OFF_TOUCH_CTRL) begin
        reg_hit[HIT_CTRL] = 1'b1;
      end else if (addr == `RTSM_OFF_ADC_SEL) begin
        reg_hit[HIT_ADC] = 1'b1;
      end else if (addr == `RTSM_OFF_INT_STATUS) begin
        reg_hit[HIT_STAT] = 1'b1;
      end else if (addr == `RTSM_OFF_INT_MASK) begin
        reg_hit[HIT_MASK] = 1'b1;
      end else if (addr == `RTSM_OFF_STATE) begin
        reg_hit[HIT_STATE] = 1'b1;
      end
    end
  endfunction

  // A terminal asked to close both of its switches at once
  function clash;
    input pwr;
    input gnd;
    begin
      clash = pwr & gnd;
    end
  endfunction

  // ========================================================================
  // Combinational decode of the matrix and mode
  // ========================================================================
  // Mode 1X needs no decode of its own: anything but 00 and 01 is position
  wire [1:0] mode = touch_ctrl[`RTSM_TC_MODE_HI:`RTSM_TC_MODE_LO];
  wire       mode_interrupt = (mode == `RTSM_MODE_INTERRUPT);
  wire       mode_pressure  = (mode == `RTSM_MODE_PRESSURE);
  wire [1:0] xp_sw = resolve(touch_ctrl[`RTSM_TC_XP_PWR], touch_ctrl[`RTSM_TC_XP_GND]);
  wire [1:0] xn_sw = resolve(touch_ctrl[`RTSM_TC_XN_PWR], touch_ctrl[`RTSM_TC_XN_GND]);
  wire [1:0] yp_sw = resolve(touch_ctrl[`RTSM_TC_YP_PWR], touch_ctrl[`RTSM_TC_YP_GND]);
  wire [1:0] yn_sw = resolve(touch_ctrl[`RTSM_TC_YN_PWR], touch_ctrl[`RTSM_TC_YN_GND]);
  wire conflict = clash(touch_ctrl[`RTSM_TC_XP_PWR], touch_ctrl[`RTSM_TC_XP_GND]) |
                  clash(touch_ctrl[`RTSM_TC_XN_PWR], touch_ctrl[`RTSM_TC_XN_GND]) |
                  clash(touch_ctrl[`RTSM_TC_YP_PWR], touch_ctrl[`RTSM_TC_YP_GND]) |
                  clash(touch_ctrl[`RTSM_TC_YN_PWR], touch_ctrl[`RTSM_TC_YN_GND]);

  // Pressed when either X terminal drops; released when both are back high
  // The detector pins are taken as already synchronous to aclk
  // X detectors feed press sensing
  wire detect_high = x_pos_detect & x_neg_detect;
  // stand-by does not gate the detectors, only the active bias
  wire press_evt   = mode_interrupt & touch_ctrl[`RTSM_TC_PRESS_EN] & detect_prev & ~detect_high;
  // release on rising edge when enabled
  wire release_evt = mode_interrupt & touch_ctrl[`RTSM_TC_RELEASE_EN] & ~detect_prev & detect_high;

  // ========================================================================
  // Switch, bias and routing outputs, registered
  // ========================================================================
  // Registering keeps a matrix rewrite from glitching a switch; a terminal with
  // neither switch closed simply floats
  always @(posedge aclk) begin
    if (!aresetn) begin
      x_plate_pos_term_pwr <= 1'b0;
      x_plate_pos_term_gnd <= 1'b0;
      x_plate_neg_term_pwr <= 1'b0;
      x_plate_neg_term_gnd <= 1'b0;
      y_plate_pos_term_pwr <= 1'b0;
      y_plate_pos_term_gnd <= 1'b0;
      y_plate_neg_term_pwr <= 1'b0;
      y_plate_neg_term_gnd <= 1'b0;
      bias_resistor_en     <= 1'b0;
      bias_circuit_en      <= 1'b0;
      adc_input_route      <= `RTSM_ADC_SEL_RESET;
    end else begin
      x_plate_pos_term_pwr <= xp_sw[1];
      x_plate_pos_term_gnd <= xp_sw[0];
      x_plate_neg_term_pwr <= xn_sw[1];
      x_plate_neg_term_gnd <= xn_sw[0];
      y_plate_pos_term_pwr <= yp_sw[1];
      y_plate_pos_term_gnd <= yp_sw[0];
      y_plate_neg_term_pwr <= yn_sw[1];
      y_plate_neg_term_gnd <= yn_sw[0];
      bias_resistor_en <= mode_interrupt;
      // Bias changes land with the switches, one cycle after the register write
      // Active bias is off in interrupt mode and in stand-by to save power
      bias_circuit_en  <= ~mode_interrupt & touch_ctrl[`RTSM_TC_BIAS_EN] &
                          ~touch_ctrl[`RTSM_TC_STANDBY];
      if (mode_pressure) begin
        adc_input_route <= `RTSM_ADC_SEL_CURMON;
      end else begin
        adc_input_route <= adc_sel;
      end
    end
  end

  // ========================================================================
  // Interrupt status, set wins over clear
  // ========================================================================
  // Decoded selects of the held write address and of the offered read address
  wire [4:0] aw_hit   = reg_hit(aw_addr);
  wire [4:0] ar_hit   = reg_hit(s_axi_araddr);
  wire       st_write = aw_held & w_held & ~s_axi_bvalid & aw_hit[HIT_STAT];
  wire [2:0] st_clear = st_write & w_strb[0] ? w_data[2:0] : 3'h0;
  wire [2:0] st_set;
  assign st_set[`RTSM_INT_PRESS]    = press_evt;
  assign st_set[`RTSM_INT_RELEASE]  = release_evt;
  assign st_set[`RTSM_INT_CONFLICT] = conflict;

  always @(posedge aclk) begin
    if (!aresetn) begin
      int_status  <= 3'h0;
      detect_prev <= 1'b1;
      irq         <= 1'b0;
    end else begin
      detect_prev <= detect_high;
      // The conflict bit re-sets every cycle while the clash stays programmed, so a
      // clear only sticks once software has mended the matrix
      int_status  <= (int_status & ~st_clear) | st_set;
      // Taken from the next status so the pin rises with the status bit, not after it
      irq         <= |(((int_status & ~st_clear) | st_set) & int_mask);
    end
  end

  // ========================================================================
  // AXI4-Lite write channel
  // ========================================================================
  // Address and data are latched independently, so either may come first; a second
  // write waits in the holding registers until the master has taken bvalid
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;

  // Byte-lane merge of a control write over the implemented bits
  wire [31:0] ctrl_merged = merge({18'h0, touch_ctrl}, w_data, w_strb);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RTSM_RESP_OKAY;
      touch_ctrl    <= `RTSM_TC_RESET;
      adc_sel       <= `RTSM_ADC_SEL_RESET;
      int_mask      <= 3'h0;
    end else begin
      // Ready is a one-cycle pulse, so a valid still held after its handshake
      // is not taken a second time
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RTSM_RESP_OKAY;
        if (aw_hit[HIT_CTRL]) begin
          // Bits 31:14 are not implemented and are dropped here on purpose
          touch_ctrl <= ctrl_merged[`RTSM_TC_WIDTH-1:0];
        end else if (aw_hit[HIT_ADC]) begin
          if (w_strb[0]) begin
            adc_sel <= w_data[2:0];
          end
        end else if (aw_hit[HIT_MASK]) begin
          if (w_strb[0]) begin
            int_mask <= w_data[2:0];
          end
        end else if (aw_hit[HIT_STAT]) begin
          // The clear itself is done in the status block
          s_axi_bresp <= `RTSM_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RTSM_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  // ========================================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RTSM_RESP_OKAY;
    end else begin
      // arready stays low while read data waits, which keeps one read in flight
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      // The address is decoded as it is taken, so it must stand with arvalid
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RTSM_RESP_OKAY;
        if (ar_hit[HIT_CTRL]) begin
          s_axi_rdata <= {18'h0, touch_ctrl};
        end else if (ar_hit[HIT_ADC]) begin
          s_axi_rdata <= {29'h0, adc_sel};
        end else if (ar_hit[HIT_STAT]) begin
          s_axi_rdata <= {29'h0, int_status};
        end else if (ar_hit[HIT_MASK]) begin
          s_axi_rdata <= {29'h0, int_mask};
        end else if (ar_hit[HIT_STATE]) begin
          // Live state: detector level, conflict, routed input, bias sources
          s_axi_rdata <= {24'h0, bias_circuit_en, bias_resistor_en, adc_input_route,
                          conflict, x_neg_detect, x_pos_detect};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RTSM_RESP_SLVERR;
        end
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: verif/rtsm_panel_model.sv
// Behavioural four-wire panel that feeds the filtered X plate detectors
`timescale 1ns/1ns

module rtsm_panel_model (
  // Switch matrix and bias from the block
  input  wire logic xp_pwr,
  input  wire logic xn_pwr,
  input  wire logic yp_gnd,
  input  wire logic yn_gnd,
  input  wire logic res_bias,
  // Stylus contact from the bench
  input  wire logic pressed,
  // Detector outputs, high while not pressed
  output wire logic x_pos_det,
  output wire logic x_neg_det
);
  // ==========================================================================
  // Plate contact
  // ==========================================================================
  // X powered, Y grounded, resistor bias
  // The X voltage only drops when a grounded Y plate is touched; otherwise the
  // resistor pulls the X plate up, so the detectors idle high.
  wire drop = pressed && res_bias && (xp_pwr || xn_pwr) && (yp_gnd || yn_gnd);
  assign x_pos_det = !drop;
  assign x_neg_det = !drop;
endmodule

// file: verif/rtsm_touch_matrix_chk.sv
// Port-level assertions for the touch matrix block
`timescale 1ns/1ns
`include "rtsm_defs.vh"

module rtsm_touch_matrix_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Panel side
  input wire logic        x_plate_pos_term_pwr,
  input wire logic        x_plate_pos_term_gnd,
  input wire logic        x_plate_neg_term_pwr,
  input wire logic        x_plate_neg_term_gnd,
  input wire logic        y_plate_pos_term_pwr,
  input wire logic        y_plate_pos_term_gnd,
  input wire logic        y_plate_neg_term_pwr,
  input wire logic        y_plate_neg_term_gnd,
  input wire logic        bias_resistor_en,
  input wire logic        bias_circuit_en,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Switch matrix and bias
  // ==========================================================================
  AST_NO_SHORT: assert property (!(x_plate_pos_term_pwr && x_plate_pos_term_gnd)
    && !(x_plate_neg_term_pwr && x_plate_neg_term_gnd) && !(y_plate_pos_term_pwr
    && y_plate_pos_term_gnd) && !(y_plate_neg_term_pwr && y_plate_neg_term_gnd))
    else $error("terminal powered and grounded together");
  AST_ONE_BIAS: assert property (!(bias_resistor_en && bias_circuit_en))
    else $error("both bias sources on");

  // ==========================================================================
  // Register bus handshakes
  // ==========================================================================
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  AST_B_AFTER_W: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_B_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == `RTSM_RESP_OKAY
    || s_axi_bresp == `RTSM_RESP_SLVERR) else $error("bad write response code");
  AST_R_AFTER_AR: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");

  // Main scenarios reached
  COV_IRQ: cover property ($rose(irq));
  COV_IRQ_RES: cover property (irq && bias_resistor_en);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == `RTSM_RESP_SLVERR);
endmodule

bind rtsm_touch_matrix rtsm_touch_matrix_chk chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .x_plate_pos_term_pwr(x_plate_pos_term_pwr), .x_plate_pos_term_gnd(x_plate_pos_term_gnd),
  .x_plate_neg_term_pwr(x_plate_neg_term_pwr), .x_plate_neg_term_gnd(x_plate_neg_term_gnd),
  .y_plate_pos_term_pwr(y_plate_pos_term_pwr), .y_plate_pos_term_gnd(y_plate_pos_term_gnd),
  .y_plate_neg_term_pwr(y_plate_neg_term_pwr), .y_plate_neg_term_gnd(y_plate_neg_term_gnd),
  .bias_resistor_en(bias_resistor_en), .bias_circuit_en(bias_circuit_en), .irq(irq));

// file: verif/tb_top.sv
// Register-level testbench for the touch matrix block with a panel model
`timescale 1ns/1ns
`include "rtsm_defs.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end

module tb_top;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pressed;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rd_data;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, irq, res_en, circ_en, xpd, xnd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] route;
  wire [7:0] sw;
  int bad_count = 0, checks = 0, cyc = 0, m;

  rtsm_touch_matrix dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .x_pos_detect(xpd), .x_neg_detect(xnd),
    .x_plate_pos_term_pwr(sw[0]), .x_plate_pos_term_gnd(sw[1]), .x_plate_neg_term_pwr(sw[2]),
    .x_plate_neg_term_gnd(sw[3]), .y_plate_pos_term_pwr(sw[4]), .y_plate_pos_term_gnd(sw[5]),
    .y_plate_neg_term_pwr(sw[6]), .y_plate_neg_term_gnd(sw[7]), .bias_resistor_en(res_en),
    .bias_circuit_en(circ_en), .adc_input_route(route), .irq(irq));

  rtsm_panel_model panel (.xp_pwr(sw[0]), .xn_pwr(sw[2]), .yp_gnd(sw[5]), .yn_gnd(sw[7]),
    .res_bias(res_en), .pressed(pressed), .x_pos_det(xpd), .x_neg_det(xnd));

  // ==========================================================================
  // Clock, reset and hang guard
  // ==========================================================================
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================================
  // Bus tasks: hold each channel until its own ready is sampled
  // ==========================================================================
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    `CHK("bresp", er, bresp)
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    rd_data = rdata;
    `CHK("rresp", er, rresp)
    `CHK("rdata", ed, rd_data)
  endtask

  // Outputs lag the register by one cycle after the response
  task settle;
    repeat (2) @(posedge aclk);
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; pressed = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(`RTSM_OFF_TOUCH_CTRL, 32'h0, `RTSM_RESP_OKAY);
    `CHK("sw reset", 8'h00, sw)
    $display("test reset done");
    for (m = 0; m < 8; m++) begin
      wr(`RTSM_OFF_TOUCH_CTRL, 32'h1 << m, `RTSM_RESP_OKAY);
      settle;
      `CHK("switch", 8'h01 << m, sw)
    end
    $display("test switches done");
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h3, `RTSM_RESP_OKAY);
    settle;
    `CHK("conflict sw", 8'h02, sw)
    wr(`RTSM_OFF_INT_MASK, 32'h4, `RTSM_RESP_OKAY);
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h0, `RTSM_RESP_OKAY);
    settle;
    `CHK("conflict irq", 1'b1, irq)
    rd(`RTSM_OFF_INT_STATUS, 32'h4, `RTSM_RESP_OKAY);
    wr(`RTSM_OFF_INT_STATUS, 32'h4, `RTSM_RESP_OKAY);
    settle;
    `CHK("irq cleared", 1'b0, irq)
    $display("test conflict done");
    wr(`RTSM_OFF_ADC_SEL, 32'h2, `RTSM_RESP_OKAY);
    // Active bias is left off whenever interrupt mode is selected
    for (m = 0; m < 4; m++) begin
      wr(`RTSM_OFF_TOUCH_CTRL, (m == 0) ? 32'h0 : 32'h1000 | (m << 10), `RTSM_RESP_OKAY);
      settle;
      `CHK("res bias", m == 0, res_en)
      `CHK("circ bias", m != 0, circ_en)
      `CHK("route", (m == 1) ? 3'h4 : 3'h2, route)
    end
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h3800, `RTSM_RESP_OKAY);
    settle;
    `CHK("standby bias", 1'b0, circ_en)
    $display("test modes done");
    // Each plate change passes through pressure mode, which also reads plate resistance
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h1409, `RTSM_RESP_OKAY);
    settle;
    `CHK("x plate sw", 8'h09, sw)
    `CHK("x plate route", 3'h4, route)
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h1809, `RTSM_RESP_OKAY);
    settle;
    `CHK("x position route", 3'h2, route)
    `CHK("x position sw", 8'h09, sw)
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h1490, `RTSM_RESP_OKAY);
    settle;
    `CHK("y plate sw", 8'h90, sw)
    wr(`RTSM_OFF_ADC_SEL, 32'h0, `RTSM_RESP_OKAY);
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h1890, `RTSM_RESP_OKAY);
    settle;
    `CHK("y position route", 3'h0, route)
    `CHK("y position bias", 1'b1, circ_en)
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h14a5, `RTSM_RESP_OKAY);
    settle;
    `CHK("pressure sw", 8'ha5, sw)
    `CHK("pressure route", 3'h4, route)
    $display("test measurements done");
    wr(`RTSM_OFF_TOUCH_CTRL, 32'h23a5, `RTSM_RESP_OKAY);
    rd(`RTSM_OFF_TOUCH_CTRL, 32'h23a5, `RTSM_RESP_OKAY);
    wr(`RTSM_OFF_INT_MASK, 32'h3, `RTSM_RESP_OKAY);
    pressed <= 1;
    settle;
    settle;
    `CHK("press irq", 1'b1, irq)
    rd(`RTSM_OFF_STATE, 32'h40, `RTSM_RESP_OKAY);
    rd(`RTSM_OFF_INT_STATUS, 32'h1, `RTSM_RESP_OKAY);
    wr(`RTSM_OFF_INT_MASK, 32'h0, `RTSM_RESP_OKAY);
    settle;
    `CHK("masked irq", 1'b0, irq)
    wr(`RTSM_OFF_INT_STATUS, 32'h1, `RTSM_RESP_OKAY);
    pressed <= 0;
    settle;
    settle;
    rd(`RTSM_OFF_INT_STATUS, 32'h2, `RTSM_RESP_OKAY);
    $display("test press done");
    rd(8'h00, 32'h0, `RTSM_RESP_SLVERR);
    wr(8'h40, 32'hffff_ffff, `RTSM_RESP_SLVERR);
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule
